// ==== logic/power_mode_wakeup_controller.sv ====
// Operating-mode controller: clock select, halt modes, power flags, wake-up.
// Assumes core strobes are on core_clk_in; pins and oscillator signals are async.
`timescale 1ns/1ns
`include "pmw_defs.svh"

// Contract
// - Mode changes only by select bit or halt
// - Select written 1 in fast: go slow
// - Slow switch completes once slow oscillator stable
// - Fast oscillator restarts, stabilises before use
// - Halt with both enables 0: sleep
// - Fast 0, slow 1: slow-only idle
// - Both enables 1: both-clocks idle
// - Fast 1, slow 0: fast-only idle
// - Memory, registers, ports retained while halted
// - Halt sets power-down, clears timeout flag
// - Halt clears watchdog; runs only if enabled
// - Wake on pin fall, interrupt, watchdog
// - Power-up or clear-watchdog clears power-down flag
// - Watchdog wake sets timeout, resets PC/SP
// - Per-pin wake enable for port A
// - Pin wake resumes after halt
// - Disabled or stack-full interrupt resumes after halt
// - Enabled interrupt with stack room serviced immediately
// - Interrupt pending before halt cannot wake
// - Select 0 fast, 1 sub; resets 1
// - Fast stable flag after 16 oscillator clocks
module power_mode_wakeup_controller
    import pmw_pkg::*;
(
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   clk_sel_wr_in,
    input  wire logic                   clk_sel_in,
    input  wire logic                   fast_osc_enable_in,
    input  wire logic                   fast_osc_idle_enable_in,
    input  wire logic                   slow_osc_idle_enable_in,
    input  wire logic                   halt_in,
    input  wire logic                   clear_watchdog_in,
    input  wire logic                   wdt_enable_in,
    input  wire logic                   wdt_overflow_in,
    input  wire logic [`PORT_A_W-1:0]   port_a_in,
    input  wire logic [`PORT_A_W-1:0]   port_a_wake_enable_in,
    input  wire logic [`IRQ_W-1:0]      irq_req_in,
    input  wire logic [`IRQ_W-1:0]      irq_enable_in,
    input  wire logic                   stack_full_in,
    input  wire logic                   fast_osc_edge_in,
    input  wire logic                   slow_osc_ready_in,
    output logic                        clk_sel_out,
    output logic                        fast_osc_stable_flag_out,
    output logic                        fast_osc_run_out,
    output logic                        sub_clock_run_out,
    output logic                        sys_clk_run_out,
    output logic                        core_run_out,
    output logic                        retain_out,
    output logic                        power_down_flag_out,
    output logic                        watchdog_timeout_flag_out,
    output logic                        wdt_clear_out,
    output logic                        wdt_run_out,
    output logic [`MODE_W-1:0]          mode_out,
    output logic                        resume_next_out,
    output logic                        irq_take_out,
    output logic                        pc_sp_reset_out
);

    ctrl_s r_ff;
    ctrl_s nxt_r;

    logic [`SYNC_W-1:0] pin_lvl;
    logic [`SYNC_W-1:0] pin_fall;
    logic [`SYNC_W-1:0] pin_rise;

    pin_sync u_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .pins_in     ({slow_osc_ready_in, fast_osc_edge_in, port_a_in}),
        .level_out   (pin_lvl),
        .fall_out    (pin_fall),
        .rise_out    (pin_rise)
    );

    logic                slow_ready;
    logic                fast_edge;
    logic                in_run;
    logic                halt_go;
    logic                pin_wake;
    logic [`IRQ_W-1:0]   irq_hit;
    logic                irq_wake;
    logic                sel_ready;

    assign slow_ready = pin_lvl[`SYNC_SLOW_READY];
    assign fast_edge  = pin_rise[`SYNC_FAST_EDGE];
    assign in_run     = (r_ff.state == ST_RUN_FAST) | (r_ff.state == ST_RUN_SLOW);
    assign halt_go    = halt_in & in_run;
    assign pin_wake   = |(pin_fall[`PORT_A_W-1:0] & port_a_wake_enable_in);
    assign irq_hit    = irq_req_in & r_ff.irq_armed;
    assign irq_wake   = |irq_hit;
    // Resume only on the clock chosen before the halt
    assign sel_ready  = r_ff.clk_sel ? slow_ready : r_ff.fast_stable;

    always_comb begin
        nxt_r     = r_ff;
        nxt_r.res = '0;
        nxt_r.wdt_clear = 1'b0;
        nxt_r.wdt_run   = wdt_enable_in;

        // Count stable oscillator edges; the flag drops as soon as it stops
        if (!r_ff.gate.fast_run) begin
            nxt_r.fast_cnt = '0;
        end else if (fast_edge && (r_ff.fast_cnt != `FAST_STABLE_CLKS)) begin
            nxt_r.fast_cnt = r_ff.fast_cnt + `FAST_CNT_W'(1);
        end
        nxt_r.fast_stable = (nxt_r.fast_cnt == `FAST_STABLE_CLKS);

        if (clear_watchdog_in && in_run) begin
            nxt_r.power_down_flag       = 1'b0;
            nxt_r.wdt_clear = 1'b1;
        end

        case (r_ff.state)
            ST_RUN_FAST: begin
                nxt_r.mode = `MODE_FAST;
                if (clk_sel_wr_in && clk_sel_in) begin
                    nxt_r.clk_sel = 1'b1;
                    nxt_r.state   = ST_TO_SLOW;
                end
            end
            ST_TO_SLOW: begin
                if (slow_ready) begin
                    nxt_r.state = ST_RUN_SLOW;
                    nxt_r.mode  = `MODE_SLOW;
                end
            end
            ST_RUN_SLOW: begin
                nxt_r.mode = `MODE_SLOW;
                if (clk_sel_wr_in && !clk_sel_in) begin
                    nxt_r.clk_sel = 1'b0;
                    nxt_r.state   = ST_TO_FAST;
                end
            end
            ST_TO_FAST: begin
                // Stay on the sub clock until the fast one has settled
                if (r_ff.fast_stable) begin
                    nxt_r.state = ST_RUN_FAST;
                    nxt_r.mode  = `MODE_FAST;
                end
            end
            ST_HALTED: begin
                if (wdt_overflow_in) begin
                    nxt_r.cause = WK_WDT;
                    nxt_r.tof   = 1'b1;
                    nxt_r.state = ST_WAKE;
                end else if (irq_wake) begin
                    if (|(irq_hit & irq_enable_in) && !stack_full_in) begin
                        nxt_r.cause = WK_IRQ_TAKE;
                    end else begin
                        nxt_r.cause = WK_IRQ_NEXT;
                    end
                    nxt_r.state = ST_WAKE;
                end else if (pin_wake) begin
                    nxt_r.cause = WK_PIN;
                    nxt_r.state = ST_WAKE;
                end
                nxt_r.woke = (nxt_r.state == ST_WAKE);
            end
            ST_WAKE: begin
                if (sel_ready) begin
                    nxt_r.state = r_ff.clk_sel ? ST_RUN_SLOW : ST_RUN_FAST;
                    nxt_r.mode  = r_ff.clk_sel ? `MODE_SLOW : `MODE_FAST;
                    nxt_r.woke  = 1'b0;
                    if (r_ff.woke) begin
                        nxt_r.res.resume_next = (r_ff.cause == WK_PIN) |
                                                (r_ff.cause == WK_IRQ_NEXT);
                        nxt_r.res.irq_take    = (r_ff.cause == WK_IRQ_TAKE);
                        nxt_r.res.pc_sp_reset = (r_ff.cause == WK_WDT);
                    end
                end
            end
            default: begin
                nxt_r.state = ST_WAKE;
            end
        endcase

        // Halt wins over a same-cycle clear-watchdog on the power-down flag
        if (halt_go) begin
            nxt_r.state     = ST_HALTED;
            nxt_r.clk_sel   = r_ff.clk_sel;
            nxt_r.power_down_flag       = 1'b1;
            nxt_r.tof       = 1'b0;
            nxt_r.wdt_clear = 1'b1;
            nxt_r.irq_armed = ~irq_req_in;
            nxt_r.woke      = 1'b0;
            case ({fast_osc_idle_enable_in, slow_osc_idle_enable_in})
                2'h0:    nxt_r.mode = `MODE_SLEEP;
                2'h1:    nxt_r.mode = `MODE_IDLE_SLOW;
                2'h3:    nxt_r.mode = `MODE_IDLE_BOTH;
                default: nxt_r.mode = `MODE_IDLE_FAST;
            endcase
        end

        nxt_r.gate = '0;
        case (nxt_r.state)
            ST_RUN_SLOW: begin
                nxt_r.gate = '{fast_run: fast_osc_enable_in, sub_run: 1'b1,
                               sys_run: 1'b1, core_run: 1'b1, retain: 1'b0};
            end
            ST_HALTED: begin
                nxt_r.gate.fast_run = (nxt_r.mode == `MODE_IDLE_BOTH) |
                                      (nxt_r.mode == `MODE_IDLE_FAST);
                nxt_r.gate.sub_run  = (nxt_r.mode == `MODE_IDLE_BOTH) |
                                      (nxt_r.mode == `MODE_IDLE_SLOW);
                nxt_r.gate.sys_run  = nxt_r.clk_sel ? nxt_r.gate.sub_run :
                                                      nxt_r.gate.fast_run;
                nxt_r.gate.retain   = 1'b1;
            end
            ST_WAKE: begin
                nxt_r.gate.fast_run = ~nxt_r.clk_sel;
                nxt_r.gate.sub_run  = 1'b1;
                nxt_r.gate.retain   = 1'b1;
            end
            default: begin
                nxt_r.gate = '{fast_run: 1'b1, sub_run: 1'b1,
                               sys_run: 1'b1, core_run: 1'b1, retain: 1'b0};
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            r_ff         <= '0;
            r_ff.state   <= ST_WAKE;
            r_ff.clk_sel <= `CLK_SEL_RESET;
            r_ff.mode    <= `MODE_SLOW;
            r_ff.gate    <= '{fast_run: 1'b0, sub_run: 1'b1,
                              sys_run: 1'b0, core_run: 1'b0, retain: 1'b1};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign clk_sel_out               = r_ff.clk_sel;
    assign fast_osc_stable_flag_out  = r_ff.fast_stable;
    assign fast_osc_run_out          = r_ff.gate.fast_run;
    assign sub_clock_run_out         = r_ff.gate.sub_run;
    assign sys_clk_run_out           = r_ff.gate.sys_run;
    assign core_run_out              = r_ff.gate.core_run;
    assign retain_out                = r_ff.gate.retain;
    assign power_down_flag_out       = r_ff.power_down_flag;
    assign watchdog_timeout_flag_out = r_ff.tof;
    assign wdt_clear_out             = r_ff.wdt_clear;
    assign wdt_run_out               = r_ff.wdt_run;
    assign mode_out                  = r_ff.mode;
    assign resume_next_out           = r_ff.res.resume_next;
    assign irq_take_out              = r_ff.res.irq_take;
    assign pc_sp_reset_out           = r_ff.res.pc_sp_reset;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_halt_mode(logic [1:0] en);
        halt_go && ({fast_osc_idle_enable_in, slow_osc_idle_enable_in} == en);
    endsequence

    sequence s_wdt_wake;
        (r_ff.state == ST_HALTED) && wdt_overflow_in;
    endsequence

    property p_halt_flags;
        halt_go |=> power_down_flag_out && !watchdog_timeout_flag_out && wdt_clear_out;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

    property p_sleep;
        s_halt_mode(2'h0) |=> !sys_clk_run_out && !fast_osc_run_out && !sub_clock_run_out
                              && !core_run_out && (mode_out == `MODE_SLEEP);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");

    property p_idle_slow;
        s_halt_mode(2'h1) |=> !fast_osc_run_out && sub_clock_run_out && !core_run_out;
    endproperty
    a_idle_slow: assert property (p_idle_slow) else $error("slow idle wrong");

    property p_idle_both;
        s_halt_mode(2'h3) |=> fast_osc_run_out && sub_clock_run_out && !core_run_out;
    endproperty
    a_idle_both: assert property (p_idle_both) else $error("dual idle wrong");

    property p_idle_fast;
        s_halt_mode(2'h2) |=> fast_osc_run_out && !sub_clock_run_out && !core_run_out;
    endproperty
    a_idle_fast: assert property (p_idle_fast) else $error("fast idle wrong");

    property p_clear_pdf;
        clear_watchdog_in && in_run && !halt_in |=> !power_down_flag_out;
    endproperty
    a_clear_pdf: assert property (p_clear_pdf) else $error("pdf not cleared");

    property p_wdt_wake;
        s_wdt_wake ##1 sel_ready |=> pc_sp_reset_out && core_run_out;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake missed");

    property p_wdt_tof;
        s_wdt_wake |=> watchdog_timeout_flag_out && (r_ff.state == ST_WAKE);
    endproperty
    a_wdt_tof: assert property (p_wdt_tof) else $error("timeout flag not set");

    property p_fast_stable;
        $rose(fast_osc_stable_flag_out) |-> $past(fast_osc_run_out) && $past(fast_edge);
    endproperty
    a_fast_stable: assert property (p_fast_stable) else $error("stable flag early");

    property p_to_fast_wait;
        (r_ff.state == ST_TO_FAST) && !r_ff.fast_stable |=> (mode_out == `MODE_SLOW);
    endproperty
    a_to_fast_wait: assert property (p_to_fast_wait) else $error("fast used early");

    property p_go_slow;
        (r_ff.state == ST_RUN_FAST) && clk_sel_wr_in && clk_sel_in && !halt_in
            |=> clk_sel_out && (r_ff.state == ST_TO_SLOW);
    endproperty
    a_go_slow: assert property (p_go_slow) else $error("slow switch missed");

    property p_pending_no_wake;
        (r_ff.state == ST_HALTED) && !wdt_overflow_in && !pin_wake
            && ((irq_req_in & ~r_ff.irq_armed) == irq_req_in) |=> (r_ff.state == ST_HALTED);
    endproperty
    a_pending_no_wake: assert property (p_pending_no_wake) else $error("stale irq woke");

endmodule

// ==== logic/pmw_defs.svh ====
// Constants for the operating-mode and wake-up controller.
// Assumes inclusion by bare name; guarded against double inclusion.
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

`define PORT_A_W          8
`define IRQ_W             8
`define SYNC_W            10
`define SYNC_FAST_EDGE    8
`define SYNC_SLOW_READY   9
`define FAST_CNT_W        5
`define FAST_STABLE_CLKS  5'h10
`define CLK_SEL_RESET     1'h1
`define MODE_W            3
`define MODE_FAST         3'h0
`define MODE_SLOW         3'h1
`define MODE_SLEEP        3'h2
`define MODE_IDLE_SLOW    3'h3
`define MODE_IDLE_BOTH    3'h4
`define MODE_IDLE_FAST    3'h5

`endif

// ==== logic/pmw_pkg.sv ====
// Types shared by the mode controller and its pin synchroniser.
// Assumes pmw_defs.svh is on the include path.
`include "pmw_defs.svh"

package pmw_pkg;

    typedef enum logic [5:0] {
        ST_RUN_FAST = 6'h01,
        ST_TO_SLOW  = 6'h02,
        ST_RUN_SLOW = 6'h04,
        ST_TO_FAST  = 6'h08,
        ST_HALTED   = 6'h10,
        ST_WAKE     = 6'h20
    } pm_state_e;

    typedef enum logic [1:0] {
        WK_PIN      = 2'h0,
        WK_IRQ_NEXT = 2'h1,
        WK_IRQ_TAKE = 2'h2,
        WK_WDT      = 2'h3
    } wake_cause_e;

    typedef struct packed {
        logic [`SYNC_W-1:0] s1;
        logic [`SYNC_W-1:0] s2;
        logic [`SYNC_W-1:0] s3;
    } sync_s;

    typedef struct packed {
        logic fast_run;
        logic sub_run;
        logic sys_run;
        logic core_run;
        logic retain;
    } clk_gate_s;

    typedef struct packed {
        logic resume_next;
        logic irq_take;
        logic pc_sp_reset;
    } resume_s;

    typedef struct packed {
        pm_state_e              state;
        logic                   clk_sel;
        logic [`FAST_CNT_W-1:0] fast_cnt;
        logic                   fast_stable;
        logic                   power_down_flag;
        logic                   tof;
        logic [`IRQ_W-1:0]      irq_armed;
        wake_cause_e            cause;
        logic                   woke;
        logic [`MODE_W-1:0]     mode;
        clk_gate_s              gate;
        resume_s                res;
        logic                   wdt_clear;
        logic                   wdt_run;
    } ctrl_s;

endpackage

// ==== logic/pin_sync.sv ====
// Two-flop synchroniser with edge detection for asynchronous pins.
// Assumes pins are asynchronous to core_clk_in; edges come from stages 2 and 3.
`timescale 1ns/1ns
`include "pmw_defs.svh"

module pin_sync
    import pmw_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    input  wire logic [`SYNC_W-1:0] pins_in,
    output logic      [`SYNC_W-1:0] level_out,
    output logic      [`SYNC_W-1:0] fall_out,
    output logic      [`SYNC_W-1:0] rise_out
);

    sync_s r_ff;
    sync_s nxt_r;

    always_comb begin
        nxt_r    = r_ff;
        nxt_r.s1 = pins_in;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `SYNC_W; i++) begin : g_bit
            assign level_out[i] = r_ff.s2[i];
            assign fall_out[i]  = r_ff.s3[i] & ~r_ff.s2[i];
            assign rise_out[i]  = ~r_ff.s3[i] & r_ff.s2[i];
        end
    endgenerate

endmodule

// ==== dv/osc_model.sv ====
// Oscillator model on the far side: fast RC clock samples and slow ready.
// Assumes run and enable levels come from the controller and the bench.
`timescale 1ns/1ns

module osc_model (
    input  wire logic fast_run_in,
    input  wire logic slow_on_in,
    output logic      fast_edge_out,
    output wire logic slow_ready_out
);
    // Stands low when stopped, so no stray edges reach the counter
    always #13 fast_edge_out = (fast_run_in === 1'h1) ? ~fast_edge_out : 1'h0;
    // Slow start-up delay; bench can hold the oscillator unstable
    assign #50 slow_ready_out = slow_on_in;
endmodule

// ==== dv/tb_power_mode_wakeup_controller.sv ====
// Self-checking bench: clock switching, halt modes, flags and wake-up causes.
// Assumes pmw_pkg and pmw_defs.svh compiled ahead of this file.
`timescale 1ns/1ns
`include "pmw_defs.svh"

module tb_power_mode_wakeup_controller;
    import pmw_pkg::*;
    logic                 core_clk_in = 1'h0;
    logic                 rst_in = 1'h1;
    logic                 clk_sel_wr_in = 1'h0, clk_sel_in = 1'h0, fast_osc_enable_in = 1'h0;
    logic                 fast_osc_idle_enable_in = 1'h0, slow_osc_idle_enable_in = 1'h0;
    logic                 halt_in = 1'h0, clear_watchdog_in = 1'h0, wdt_enable_in = 1'h0;
    logic                 wdt_overflow_in = 1'h0, stack_full_in = 1'h0, slow_on = 1'h1;
    logic [`PORT_A_W-1:0] port_a_in = 8'hff, port_a_wake_enable_in = 8'h00;
    logic [`IRQ_W-1:0]    irq_req_in = 8'h00, irq_enable_in = 8'h00;
    wire logic            fast_osc_edge_in, slow_osc_ready_in;
    logic                 clk_sel_out, fast_osc_stable_flag_out, fast_osc_run_out;
    logic                 sub_clock_run_out, sys_clk_run_out, core_run_out, retain_out;
    logic                 power_down_flag_out, watchdog_timeout_flag_out, wdt_clear_out;
    logic                 wdt_run_out, resume_next_out, irq_take_out, pc_sp_reset_out;
    logic [`MODE_W-1:0]   mode_out;
    logic [2:0]           md_tab [4] = '{`MODE_SLEEP, `MODE_IDLE_SLOW, `MODE_IDLE_BOTH,
                                         `MODE_IDLE_FAST};
    logic [3:0]           notes [$];
    logic [3:0]           note;
    int                   err_count = 0, n_tests = 0, waited, seed, pin;

    always #5 core_clk_in = ~core_clk_in;

    power_mode_wakeup_controller power_mode_wakeup_controller_i (.*);
    osc_model osc_model_i (
        .fast_run_in    (fast_osc_run_out),
        .slow_on_in     (slow_on & sub_clock_run_out),
        .fast_edge_out  (fast_osc_edge_in),
        .slow_ready_out (slow_osc_ready_in)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    // 0 core running, 1 fast mode, 2 slow mode; bounded so a hang ends the run
    task automatic wait_for(input int k);
        logic hit;
        hit = 1'h0;
        for (waited = 0; waited < 300 && !hit; waited++) begin
            cyc(1);
            #1;
            case (k)
                0: hit = (core_run_out === 1'h1);
                1: hit = (mode_out === `MODE_FAST);
                default: hit = (mode_out === `MODE_SLOW);
            endcase
        end
        if (!hit) begin
            err_count++;
            $display("[ERR] %0t wait %0d timed out", $time, k);
            end_of_test();
        end
    endtask

    // Each wake answer is checked against the oldest note
    always @(negedge core_clk_in) begin
        if ((resume_next_out | irq_take_out | pc_sp_reset_out) === 1'h1) begin
            if (notes.size() == 0) begin
                chk(8'h00, 8'hff);
            end else begin
                note = notes.pop_front();
                chk({4'h0, resume_next_out, irq_take_out, pc_sp_reset_out,
                     watchdog_timeout_flag_out}, {4'h0, note});
            end
        end
    end

    initial begin
        seed = 32'h81a8_7152;
        cyc(11);
        #1 chk({3'h0, clk_sel_out, power_down_flag_out, watchdog_timeout_flag_out, core_run_out,
                retain_out}, 8'h11);
        cyc(1);
        rst_in <= 1'h0;
        // Requests before the core runs would be refused
        wait_for(0);
        chk({4'h0, clk_sel_out, mode_out}, 8'h09);
        cyc(1);
        clk_sel_wr_in <= 1'h1;
        clk_sel_in <= 1'h0;
        cyc(1);
        clk_sel_wr_in <= 1'h0;
        #1 chk({3'h0, clk_sel_out, fast_osc_stable_flag_out, mode_out}, 8'h01);
        wait_for(1);
        chk({7'h00, fast_osc_stable_flag_out}, 8'h01);
        chk({7'h00, waited >= 30}, 8'h01);
        cyc(1);
        slow_on <= 1'h0;
        cyc(8);
        clk_sel_wr_in <= 1'h1;
        clk_sel_in <= 1'h1;
        cyc(1);
        clk_sel_wr_in <= 1'h0;
        cyc(10);
        #1 chk({4'h0, clk_sel_out, mode_out}, 8'h08);
        cyc(1);
        slow_on <= 1'h1;
        wait_for(2);
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            fast_osc_idle_enable_in <= i[1];
            slow_osc_idle_enable_in <= i[1] ^ i[0];
            wdt_enable_in <= 1'($random(seed));
            pin = $random(seed) & 7;
            port_a_wake_enable_in <= 8'h01 << pin;
            irq_req_in <= (i == 0) ? 8'h80 : 8'h00;
            cyc(1);
            halt_in <= 1'h1;
            cyc(1);
            halt_in <= 1'h0;
            #1 chk({fast_osc_run_out, sub_clock_run_out, core_run_out, retain_out,
                    power_down_flag_out, mode_out},
                   {i[1], i[1] ^ i[0], 3'h3, md_tab[i]});
            chk({5'h00, sys_clk_run_out, watchdog_timeout_flag_out, wdt_clear_out},
                {5'h00, i[1] ^ i[0], 2'h1});
            cyc(1);
            #1 chk({6'h00, wdt_clear_out, wdt_run_out}, {7'h00, wdt_enable_in});
            cyc(1);
            case (i)
                0: begin
                    port_a_in <= ~(8'h01 << ((pin ^ 1) & 7));
                    cyc(10);
                    #1 chk({6'h00, core_run_out, retain_out}, 8'h01);
                    cyc(1);
                    notes.push_back(4'h8);
                    port_a_in <= ~((8'h01 << pin) | (8'h01 << ((pin ^ 1) & 7)));
                end
                1: begin
                    notes.push_back(4'h8);
                    irq_enable_in <= 8'h01;
                    stack_full_in <= 1'h1;
                    irq_req_in <= 8'h01;
                end
                2: begin
                    notes.push_back(4'h4);
                    irq_enable_in <= 8'h01;
                    irq_req_in <= 8'h01;
                end
                default: begin
                    notes.push_back(4'h3);
                    wdt_overflow_in <= 1'h1;
                    cyc(1);
                    wdt_overflow_in <= 1'h0;
                end
            endcase
            wait_for(0);
            chk({4'h0, power_down_flag_out, mode_out}, 8'h09);
            cyc(1);
            port_a_in <= 8'hff;
            irq_req_in <= 8'h00;
            irq_enable_in <= 8'h00;
            stack_full_in <= 1'h0;
        end
        cyc(2);
        clear_watchdog_in <= 1'h1;
        cyc(1);
        clear_watchdog_in <= 1'h0;
        #1 chk({6'h00, power_down_flag_out, wdt_clear_out}, 8'h01);
        chk(8'(notes.size()), 8'h00);
        end_of_test();
    end
endmodule
